// *** common/rpkt_pkg.sv ***
// Constants shared by the packet framer and mode sequencer
package rpkt_pkg;
	// Clock and timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int SLEEP_TO_CONFIG_DELAY_US = 3000;
	localparam int SLEEP_TO_CONFIG_CYCLES = SLEEP_TO_CONFIG_DELAY_US * 1000 / CLK_PERIOD_NS;
	localparam int IDLE_TO_BURST_TX_DELAY_NS = 195000;
	localparam int IDLE_TO_DIRECT_TX_DELAY_NS = 202000;
	localparam int IDLE_TO_RECEIVE_DELAY_NS = 202000;
	localparam int BURST_TX_CYCLES = IDLE_TO_BURST_TX_DELAY_NS / CLK_PERIOD_NS;
	localparam int DIRECT_TX_CYCLES = IDLE_TO_DIRECT_TX_DELAY_NS / CLK_PERIOD_NS;
	localparam int RECEIVE_CYCLES = IDLE_TO_RECEIVE_DELAY_NS / CLK_PERIOD_NS;
	localparam int BIT_FAST_NS = 1000;
	localparam int BIT_SLOW_NS = 4000;
	localparam logic [5:0] BIT_FAST_CYCLES = 6'(BIT_FAST_NS / CLK_PERIOD_NS);
	localparam logic [5:0] BIT_SLOW_CYCLES = 6'(BIT_SLOW_NS / CLK_PERIOD_NS);
	localparam int CNT_W = 24;
	// Packet layout
	localparam int PKT_MAX_BITS = 256;
	localparam int PRE_BITS = 8;
	localparam logic [7:0] PRE_ZERO = 8'h55;
	localparam logic [7:0] PRE_ONE = 8'hAA;
	localparam logic [5:0] ADDR_MIN = 6'h08;
	localparam logic [5:0] ADDR_MAX = 6'h28;
	localparam logic [8:0] CRC_SHORT = 9'h008;
	localparam logic [8:0] CRC_LONG = 9'h010;
	localparam logic [15:0] CRC_POLY_SHORT = 16'h0007;
	localparam logic [15:0] CRC_POLY_LONG = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	// Configuration word fields
	localparam int CFG_W = 24;
	localparam int CFG_RX_BIT = 0;
	localparam int CFG_RATE_BIT = 13;
	localparam int CFG_BURST_BIT = 14;
	localparam int CFG_CRC_EN_BIT = 16;
	localparam int CFG_CRC_L_BIT = 17;
	localparam int CFG_ADDR_W_LSB = 18;
	localparam logic [23:0] CFG_RESET = 24'h210F04;
	// Register map
	localparam logic [7:0] REG_ADDR_LO = 8'h00;
	localparam logic [7:0] REG_ADDR_HI = 8'h04;
	localparam logic [7:0] REG_PAYLOAD_W = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_CONFIG = 8'h10;
	localparam int ST_CRC_ERR_BIT = 8;
	localparam logic [8:0] PAYLOAD_W_RESET = 9'h020;
	// Synchroniser lanes
	localparam int SY_CE = 0;
	localparam int SY_CS = 1;
	localparam int SY_SCLK = 2;
	localparam int SY_DIN = 3;
	localparam int SY_PWR = 4;
endpackage

// *** design/rpkt_bitmem.sv ***
// Single-bit packet buffer with registered read data
`timescale 1ns/1ps
module rpkt_bitmem #(
	parameter int DEPTH = 256,
	parameter int AW = 8
)(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	// Write port
	input wire logic i_we,
	input wire logic [AW-1:0] i_waddr,
	input wire logic i_wbit,
	// Read port
	input wire logic [AW-1:0] i_raddr,
	output logic o_rbit
);
	logic mem [DEPTH];

	// Storage needs no reset; only the read register does
	always_ff @(posedge i_sys_clk)
	begin
		if (i_we)
		begin
			mem[i_waddr] <= i_wbit;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_rbit <= 1'b0;
		end
		else
		begin
			o_rbit <= mem[i_raddr];
		end
	end
endmodule

// *** design/rpkt_sequencer.sv ***
// Packet framer and operating-mode sequencer of the radio host link
//
// Overview of operation
// - Preamble 55 or AA from first address bit
// - Device adds preamble on burst transmit
// - Burst receive strips preamble; direct passes it
// - Burst address 8 to 40 bits, stripped
// - Payload capped at 256 minus address, CRC
// - Optional 8/16-bit CRC, burst only, stripped
// - Start-up delays 195us burst transmit, 202us others
// - Configuration lost on reset; needed before active
// - Burst airtime is bits plus one period
// - Config bit 14 selects burst mode
// - Config bit 17 selects 16-bit CRC
// - Config bits 23:18 give address width
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module rpkt_sequencer
	import rpkt_pkg::*;
#(
	parameter int SETTLE_CYCLES = SLEEP_TO_CONFIG_CYCLES,
	parameter int BUF_DEPTH = PKT_MAX_BITS
)(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	// Host pins
	input wire logic i_pwr_up,
	input wire logic i_ce,
	input wire logic i_cs,
	input wire logic i_sclk,
	input wire logic i_data,
	output logic o_data,
	output logic o_data_oe,
	output logic o_rx_ready_first,
	// Radio front end
	output logic o_air_bit,
	output logic o_air_active,
	output logic o_demod_on,
	input wire logic i_air_bit,
	input wire logic i_air_strobe,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata
);
	typedef enum logic [3:0] {sleep_state, settle_state, idle_state, config_state,
		tx_load_state, tx_start_state, tx_air_state, dtx_start_state, dtx_air_state,
		rx_start_state, rx_direct_state, rx_hunt_state, rx_body_state, rx_read_state
	} rpkt_state_type;

	function automatic logic [15:0] crc_step(logic [15:0] c, logic b, logic wide);
		logic fb;
		logic [15:0] r;
		fb = b ^ (wide ? c[15] : c[7]);
		r = {c[14:0], 1'b0} ^ (fb ? (wide ? CRC_POLY_LONG : CRC_POLY_SHORT) : 16'h0000);
		return wide ? r : {8'h00, r[7:0]};
	endfunction

	function automatic logic crc_bit(logic [15:0] c, logic [8:0] k, logic wide);
		return wide ? c[4'(15 - k)] : c[3'(7 - k)];
	endfunction

	logic [4:0] sync1, sync2;
	logic sclk_d;
	rpkt_state_type state, next_state;
	logic [CNT_W-1:0] cnt, next_cnt;
	logic [5:0] btimer, next_btimer;
	logic [8:0] pos, next_pos, wptr, next_wptr, rptr, next_rptr;
	logic [15:0] crc, next_crc;
	logic [7:0] win, next_win;
	logic [CFG_W-1:0] cfg, next_cfg, cfg_sh, next_cfg_sh;
	logic configured, next_configured, first_bit, next_first_bit;
	logic rx_bad, next_rx_bad, crc_err, next_crc_err;
	logic next_data, next_data_oe, next_rx_ready, next_air_bit, next_air_active;
	logic [31:0] addr_lo, next_addr_lo, next_rdata;
	logic [7:0] addr_hi, next_addr_hi;
	logic [8:0] pay_w, next_pay_w;
	logic mem_we, mem_wbit, mem_rbit;
	logic [7:0] mem_waddr, mem_raddr;
	logic s_ce, s_cs, s_din, s_pwr, sclk_rise;
	logic [39:0] addr40;
	logic [5:0] aw, aw_raw, bitp;
	logic [8:0] clen, plen, room;
	logic wide, in_bit, crc_fail;

	assign s_ce = sync2[SY_CE];
	assign s_cs = sync2[SY_CS];
	assign s_din = sync2[SY_DIN];
	assign s_pwr = sync2[SY_PWR];
	assign sclk_rise = sync2[SY_SCLK] & ~sclk_d;
	assign addr40 = {addr_hi, addr_lo};
	assign aw_raw = cfg[CFG_ADDR_W_LSB +: 6];
	assign aw = (aw_raw < ADDR_MIN) ? ADDR_MIN : ((aw_raw > ADDR_MAX) ? ADDR_MAX : aw_raw);
	assign wide = cfg[CFG_CRC_L_BIT];
	assign clen = cfg[CFG_CRC_EN_BIT] ? (wide ? CRC_LONG : CRC_SHORT) : 9'h000;
	assign bitp = cfg[CFG_RATE_BIT] ? BIT_FAST_CYCLES : BIT_SLOW_CYCLES;
	// payload room left after address and CRC
	assign room = 9'(PKT_MAX_BITS) - {3'b000, aw} - clen;
	assign plen = (pay_w > room || pay_w == 9'h000) ? room : pay_w;
	assign in_bit = i_air_bit;

	rpkt_bitmem #(.DEPTH(BUF_DEPTH), .AW(8)) u_buf (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_we(mem_we),
		.i_waddr(mem_waddr),
		.i_wbit(mem_wbit),
		.i_raddr(mem_raddr),
		.o_rbit(mem_rbit)
	);

	always_comb
	begin
		next_state = state;
		next_cnt = (cnt != '0) ? cnt - 1'b1 : cnt;
		next_btimer = btimer;
		next_pos = pos;
		next_wptr = wptr;
		next_rptr = rptr;
		next_crc = crc;
		next_win = win;
		next_cfg = cfg;
		next_cfg_sh = cfg_sh;
		next_configured = configured;
		next_first_bit = first_bit;
		next_rx_bad = rx_bad;
		next_crc_err = crc_err;
		next_data = o_data;
		next_rx_ready = 1'b0;
		next_air_bit = o_air_bit;
		next_air_active = 1'b0;
		mem_we = 1'b0;
		crc_fail = 1'b0;
		mem_waddr = wptr[7:0];
		mem_wbit = s_din;
		mem_raddr = (state == tx_air_state) ? 8'(pos - 9'(PRE_BITS)) : rptr[7:0];
		// mode sequencing on enable and select
		unique case (state)
			sleep_state:
			begin
				next_cnt = CNT_W'(SETTLE_CYCLES);
				next_state = settle_state;
			end
			settle_state:
			begin
				if (cnt == '0)
					next_state = idle_state;
			end
			idle_state:
			begin
				next_pos = '0;
				next_wptr = '0;
				next_rptr = '0;
				next_crc = CRC_INIT;
				next_win = 8'h00;
				if (s_cs && !s_ce)
					next_state = config_state;
				else if (s_ce && !s_cs && configured)
				begin
					if (cfg[CFG_RX_BIT])
					begin
						next_cnt = CNT_W'(RECEIVE_CYCLES);
						next_state = rx_start_state;
					end
					else if (cfg[CFG_BURST_BIT])
						next_state = tx_load_state;
					else
					begin
						next_cnt = CNT_W'(DIRECT_TX_CYCLES);
						next_state = dtx_start_state;
					end
				end
			end
			config_state:
			begin
				// Last bits shifted in land in the low field positions
				if (sclk_rise)
					next_cfg_sh = {cfg_sh[CFG_W-2:0], s_din};
				if (!s_cs)
				begin
					next_cfg = cfg_sh;
					next_configured = 1'b1;
					next_state = idle_state;
				end
			end
			tx_load_state:
			begin
				if (sclk_rise && (wptr < 9'(PKT_MAX_BITS) - clen))
				begin
					mem_we = 1'b1;
					next_wptr = wptr + 1'b1;
					if (wptr == '0)
						next_first_bit = s_din;
				end
				if (!s_ce)
				begin
					next_cnt = CNT_W'(BURST_TX_CYCLES);
					next_state = tx_start_state;
				end
			end
			tx_start_state:
			begin
				next_btimer = bitp - 1'b1;
				if (cnt == '0)
					next_state = tx_air_state;
			end
			tx_air_state:
			begin
				next_air_active = 1'b1;
				if (btimer == bitp - 6'h02)
				begin
					// preamble made here from first bit
					if (pos < 9'(PRE_BITS))
						next_air_bit = first_bit ? PRE_ONE[3'(7 - pos)] : PRE_ZERO[3'(7 - pos)];
					else if (pos < 9'(PRE_BITS) + wptr)
					begin
						next_air_bit = mem_rbit;
						next_crc = crc_step(crc, mem_rbit, wide);
					end
					else if (pos < 9'(PRE_BITS) + wptr + clen)
						next_air_bit = crc_bit(crc, pos - 9'(PRE_BITS) - wptr, wide);
					else
						next_air_bit = 1'b0;
				end
				if (btimer == '0)
				begin
					next_btimer = bitp - 1'b1;
					next_pos = pos + 1'b1;
					// one extra bit period after the last bit
					if (pos == 9'(PRE_BITS) + wptr + clen)
					begin
						next_state = idle_state;
					end
				end
				else
					next_btimer = btimer - 1'b1;
			end
			dtx_start_state:
			begin
				if (cnt == '0)
					next_state = dtx_air_state;
			end
			dtx_air_state:
			begin
				next_air_active = s_ce;
				next_air_bit = s_din;
				if (!s_ce)
					next_state = idle_state;
			end
			rx_start_state:
			begin
				if (cnt == '0)
					next_state = cfg[CFG_BURST_BIT] ? rx_hunt_state : rx_direct_state;
			end
			rx_direct_state:
			begin
				// direct receive passes every bit through
				next_data = in_bit;
				if (!s_ce)
					next_state = idle_state;
			end
			rx_hunt_state:
			begin
				next_pos = '0;
				next_crc = CRC_INIT;
				next_rx_bad = 1'b0;
				if (i_air_strobe)
				begin
					next_win = {win[6:0], in_bit};
					if ({win[6:0], in_bit} == (addr40[aw - 1'b1] ? PRE_ONE : PRE_ZERO))
						next_state = rx_body_state;
				end
				if (!s_ce)
					next_state = idle_state;
			end
			rx_body_state:
			begin
				// Empty window on re-hunt; a stale preamble tail would match early
				next_win = 8'h00;
				if (i_air_strobe)
				begin
					next_pos = pos + 1'b1;
					if (pos < 9'(aw))
					begin
						next_crc = crc_step(crc, in_bit, wide);
						if (in_bit != addr40[6'(aw - 1'b1 - pos[5:0])])
							next_state = rx_hunt_state;
					end
					else if (pos < 9'(aw) + plen)
					begin
						mem_we = 1'b1;
						mem_waddr = 8'(pos - 9'(aw));
						mem_wbit = in_bit;
						next_crc = crc_step(crc, in_bit, wide);
					end
					else if (in_bit != crc_bit(crc, pos - 9'(aw) - plen, wide))
						next_rx_bad = 1'b1;
					if (pos == 9'(aw) + plen + clen - 1'b1 && next_state == rx_body_state)
					begin
						if (next_rx_bad)
						begin
							next_crc_err = 1'b1;
							crc_fail = 1'b1;
							next_state = rx_hunt_state;
						end
						else
						begin
							next_rx_ready = 1'b1;
							next_state = rx_read_state;
						end
					end
				end
				if (!s_ce)
					next_state = idle_state;
			end
			rx_read_state:
			begin
				next_rx_ready = 1'b1;
				next_data = mem_rbit;
				if (sclk_rise)
				begin
					next_rptr = rptr + 1'b1;
					if (rptr == plen - 1'b1)
					begin
						next_rx_ready = 1'b0;
						next_rptr = '0;
						next_state = s_ce ? rx_hunt_state : idle_state;
					end
				end
			end
		endcase
		if (!s_pwr)
		begin
			next_state = sleep_state;
			next_air_active = 1'b0;
			next_rx_ready = 1'b0;
		end
		next_data_oe = (next_state == rx_read_state) || (next_state == rx_direct_state);
		// Software clear loses to a fresh CRC failure
		if (i_wr && i_addr == REG_STATUS && i_wdata[ST_CRC_ERR_BIT] && !crc_fail)
			next_crc_err = 1'b0;
	end

	always_comb
	begin
		next_addr_lo = addr_lo;
		next_addr_hi = addr_hi;
		next_pay_w = pay_w;
		next_rdata = 32'h00000000;
		if (i_wr)
		begin
			unique case (i_addr)
				REG_ADDR_LO: next_addr_lo = i_wdata;
				REG_ADDR_HI: next_addr_hi = i_wdata[7:0];
				REG_PAYLOAD_W: next_pay_w = i_wdata[8:0];
				default: ;
			endcase
		end
		if (i_rd)
		begin
			unique case (i_addr)
				REG_ADDR_LO: next_rdata = addr_lo;
				REG_ADDR_HI: next_rdata = {24'h000000, addr_hi};
				REG_PAYLOAD_W: next_rdata = {23'h000000, pay_w};
				REG_STATUS: next_rdata = {23'h000000, crc_err, s_cs, s_ce, o_rx_ready_first,
					configured, state};
				REG_CONFIG: next_rdata = {8'h00, cfg};
				default: next_rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			sync1 <= 5'h00;
			sync2 <= 5'h00;
			sclk_d <= 1'b0;
			state <= sleep_state;
			cnt <= '0;
			btimer <= 6'h00;
			pos <= 9'h000;
			wptr <= 9'h000;
			rptr <= 9'h000;
			crc <= CRC_INIT;
			win <= 8'h00;
			cfg <= CFG_RESET;
			cfg_sh <= CFG_RESET;
			configured <= 1'b0;
			first_bit <= 1'b0;
			rx_bad <= 1'b0;
			crc_err <= 1'b0;
			o_data <= 1'b0;
			o_data_oe <= 1'b0;
			o_rx_ready_first <= 1'b0;
			o_air_bit <= 1'b0;
			o_air_active <= 1'b0;
			o_demod_on <= 1'b0;
			addr_lo <= 32'h00000000;
			addr_hi <= 8'h00;
			pay_w <= PAYLOAD_W_RESET;
			o_rdata <= 32'h00000000;
		end
		else
		begin
			sync1 <= {i_pwr_up, i_data, i_sclk, i_cs, i_ce};
			sync2 <= sync1;
			sclk_d <= sync2[SY_SCLK];
			state <= next_state;
			cnt <= next_cnt;
			btimer <= next_btimer;
			pos <= next_pos;
			wptr <= next_wptr;
			rptr <= next_rptr;
			crc <= next_crc;
			win <= next_win;
			cfg <= next_cfg;
			cfg_sh <= next_cfg_sh;
			configured <= next_configured;
			first_bit <= next_first_bit;
			rx_bad <= next_rx_bad;
			crc_err <= next_crc_err;
			o_data <= next_data;
			o_data_oe <= next_data_oe;
			o_rx_ready_first <= next_rx_ready;
			o_air_bit <= next_air_bit;
			o_air_active <= next_air_active;
			// demodulation starts after the receive delay
			o_demod_on <= (next_state == rx_direct_state) || (next_state == rx_hunt_state)
				|| (next_state == rx_body_state);
			addr_lo <= next_addr_lo;
			addr_hi <= next_addr_hi;
			pay_w <= next_pay_w;
			o_rdata <= next_rdata;
		end
	end
endmodule

// *** verification/rpkt_seq_asserts.sv ***
// Port-level assertions for the packet sequencer
`timescale 1ns/1ps
module rpkt_seq_asserts (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	// Watched pins
	input wire logic i_pwr_up,
	input wire logic o_data_oe,
	input wire logic o_rx_ready_first,
	input wire logic o_air_bit,
	input wire logic o_air_active,
	input wire logic o_demod_on
);
	logic [15:0] air_cnt;
	logic [15:0] next_air_cnt;
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rstn);
	always_comb
	begin
		next_air_cnt = o_air_active ? air_cnt + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			air_cnt <= 16'h0000;
		else
			air_cnt <= next_air_cnt;
	end
	a_sleep_quiet: assert property (!i_pwr_up [*6] |-> !o_air_active && !o_demod_on)
		else $error("radio busy while powered down");
	a_tx_rx_apart: assert property (!(o_air_active && o_demod_on))
		else $error("transmit and receive at once");
	a_oe_not_tx: assert property (o_data_oe |-> !o_air_active)
		else $error("data pin driven while transmitting");
	a_ready_quiet: assert property (o_rx_ready_first |-> !o_air_active && !o_demod_on)
		else $error("data ready outside readout");
	a_ready_drives: assert property ($rose(o_rx_ready_first) |-> ##[0:2] o_data_oe)
		else $error("data pin not driven for readout");
	a_airtime_min: assert property ($rose(o_air_active) |=> o_air_active [*8])
		else $error("frame shorter than preamble");
	// Longest frame at the slow rate bounds the counter
	a_airtime_max: assert property (air_cnt <= 16'h2968)
		else $error("frame longer than packet limit");
	a_preamble_alt: assert property ($rose(o_air_active) ##15 1'b1 |->
		o_air_bit != $past(o_air_bit, 10))
		else $error("preamble does not alternate");
endmodule

bind rpkt_sequencer rpkt_seq_asserts u_chk (
	.i_sys_clk(i_sys_clk),
	.i_rstn(i_rstn),
	.i_pwr_up(i_pwr_up),
	.o_data_oe(o_data_oe),
	.o_rx_ready_first(o_rx_ready_first),
	.o_air_bit(o_air_bit),
	.o_air_active(o_air_active),
	.o_demod_on(o_demod_on)
);

// *** verification/rpkt_host_model.sv ***
// Host controller model driving enable, select and serial pins
`timescale 1ns/1ps
module rpkt_host_model (
	// Clock
	input wire logic i_sys_clk,
	// Pins toward the device
	output logic o_ce,
	output logic o_cs,
	output logic o_sclk,
	output logic o_data,
	output logic o_data_oe,
	input wire logic i_line
);
	initial
	begin
		o_ce = 1'b0;
		o_cs = 1'b0;
		o_sclk = 1'b0;
		o_data = 1'b0;
		o_data_oe = 1'b0;
	end
	// Released line toggles so a stale value never reads as valid
	always @(posedge i_sys_clk)
	begin
		if (!o_data_oe)
			o_data <= ~o_data;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge i_sys_clk);
	endtask
	// enable only while select is low
	task automatic enable(input logic v);
		@(posedge i_sys_clk);
		o_ce <= v;
	endtask
	// clock idles low; one bit period before mode change
	task automatic send(input logic [255:0] v, input int n);
		@(posedge i_sys_clk);
		o_data_oe <= 1'b1;
		tick(1);
		for (int i = n - 1; i >= 0; i--)
		begin
			o_data <= v[i];
			tick(4);
			o_sclk <= 1'b1;
			tick(4);
			o_sclk <= 1'b0;
		end
		tick(10);
		o_data_oe <= 1'b0;
	endtask
	// select alone, wait before first bit
	task automatic configure(input logic [23:0] cfg);
		@(posedge i_sys_clk);
		o_cs <= 1'b1;
		tick(50);
		send({232'h0, cfg}, 24);
		o_cs <= 1'b0;
		tick(10);
	endtask
	// enable may stay high during readout
	task automatic fetch(input int n, output logic [255:0] v);
		v = 256'h0;
		for (int i = n - 1; i >= 0; i--)
		begin
			tick(4);
			v[i] = i_line;
			o_sclk <= 1'b1;
			tick(4);
			o_sclk <= 1'b0;
		end
	endtask
	// host frames direct packets, clock low, far under 4ms
	task automatic direct(input int n);
		tick(50);
		o_data_oe <= 1'b1;
		tick(1);
		for (int i = 0; i < n; i++)
		begin
			o_data <= i[0];
			tick(10);
		end
		o_data_oe <= 1'b0;
	endtask
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the packet sequencer
`timescale 1ns/1ps
module tb_top;
	import rpkt_pkg::*;
	logic i_sys_clk, i_rstn, i_pwr_up, i_ce, i_cs, i_sclk, h_data, h_oe, line;
	logic o_data, o_data_oe, o_rx_ready_first, o_air_bit, o_air_active, o_demod_on;
	logic i_air_bit, i_air_strobe, i_wr, i_rd, l;
	logic [7:0] i_addr, adr;
	logic [31:0] i_wdata, o_rdata, d;
	logic [255:0] v, got;
	logic [23:0] cfg;
	logic exp_q[$];
	int mismatches, num_checks, cycles, air_len, w, n, plen, k;
	assign line = o_data_oe ? o_data : h_data;
	rpkt_sequencer #(.SETTLE_CYCLES(50), .BUF_DEPTH(256)) uut (.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn), .i_pwr_up(i_pwr_up), .i_ce(i_ce), .i_cs(i_cs), .i_sclk(i_sclk),
		.i_data(line), .o_data(o_data), .o_data_oe(o_data_oe),
		.o_rx_ready_first(o_rx_ready_first), .o_air_bit(o_air_bit),
		.o_air_active(o_air_active), .o_demod_on(o_demod_on), .i_air_bit(i_air_bit),
		.i_air_strobe(i_air_strobe), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata));
	rpkt_host_model host (.i_sys_clk(i_sys_clk), .o_ce(i_ce), .o_cs(i_cs),
		.o_sclk(i_sclk), .o_data(h_data), .o_data_oe(h_oe), .i_line(line));
	initial
	begin
		i_sys_clk = 1'b0;
		forever #50 i_sys_clk = ~i_sys_clk;
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Hang guard well above the expected run length
	always @(posedge i_sys_clk)
	begin
		cycles++;
		if (o_air_active)
			air_len++;
		// host and device never drive the data pin together
		if (h_oe && o_data_oe)
			check("pin contention", 32'h1, 32'h0);
		if (cycles == 40000)
		begin
			mismatches++;
			final_report();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] dv);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_wdata <= dv;
		i_wr <= 1'b1;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] dv);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1 dv = o_rdata;
	endtask
	task automatic wait_hi(ref logic s, input int lim, output int c);
		c = 0;
		while (s !== 1'b1 && c < lim)
		begin
			@(posedge i_sys_clk);
			c++;
		end
	endtask
	function automatic void add(input logic [255:0] x, input int m);
		for (int i = m - 1; i >= 0; i--)
			exp_q.push_back(x[i]);
	endfunction
	function automatic logic [15:0] crc_of(input logic [255:0] x, input int m, input logic ln);
		logic [15:0] c;
		logic fb;
		c = CRC_INIT;
		for (int i = m - 1; i >= 0; i--)
		begin
			fb = x[i] ^ (ln ? c[15] : c[7]);
			c = c << 1;
			if (fb)
				c = c ^ (ln ? CRC_POLY_LONG : CRC_POLY_SHORT);
		end
		return ln ? c : {8'h00, c[7:0]};
	endfunction
	// preamble from first bit, check bits last
	function automatic void frame(input logic [255:0] x, input int m, input logic ln);
		exp_q.delete();
		add({248'h0, x[m-1] ? PRE_ONE : PRE_ZERO}, 8);
		add(x, m);
		add({240'h0, crc_of(x, m, ln)}, ln ? 16 : 8);
	endfunction
	task automatic air_feed();
		foreach (exp_q[i])
		begin
			@(posedge i_sys_clk);
			i_air_bit <= exp_q[i];
			i_air_strobe <= 1'b1;
			@(posedge i_sys_clk);
			i_air_strobe <= 1'b0;
			host.tick(8);
		end
	endtask
	initial
	begin
		{i_rstn, i_pwr_up, i_air_bit, i_air_strobe, i_wr, i_rd} = 6'h00;
		i_addr = 8'h00;
		i_wdata = 32'h0;
		void'($urandom(4));
		repeat (20) @(posedge i_sys_clk);
		i_rstn <= 1'b1;
		wr(REG_CONFIG, 32'h0);
		adr = 8'h14 + 8'($urandom_range(0, 7) << 2);
		wr(adr, $urandom);
		rd(REG_CONFIG, d);
		check("config reset", d, {8'h00, CFG_RESET});
		rd(REG_PAYLOAD_W, d);
		check("payload width", d, {23'h0, PAYLOAD_W_RESET});
		rd(adr, d);
		check("unmapped", d, 32'h0);
		rd(REG_STATUS, d);
		check("status sleep", d, 32'h0);
		i_pwr_up <= 1'b1;
		// settle in standby before anything else
		host.tick(70);
		rd(REG_STATUS, d);
		check("status idle", d, 32'h2);
		host.enable(1'b1);
		host.tick(2100);
		rd(REG_STATUS, d);
		check("refused enable", d, 32'h42);
		host.enable(1'b0);
		$display("reset and refusal test done");
		for (k = 0; k < 2; k++)
		begin
			l = k[0];
			plen = 4 + $urandom_range(0, 16);
			n = plen + 8;
			adr = 8'hA5 ^ 8'($urandom_range(0, 3) << 3);
			v = 256'({$urandom, $urandom});
			v[plen +: 8] = adr;
			cfg = 24'h216F04 | (24'(l) << 17);
			host.configure(cfg);
			rd(REG_CONFIG, d);
			check("config word", d, {8'h00, cfg});
			host.enable(1'b1);
			host.tick(50);
			host.send(v, n);
			air_len = 0;
			host.enable(1'b0);
			wait_hi(o_air_active, 2100, w);
			check("burst start", 32'(w > 1945 && w < 1960), 32'h1);
			frame(v, n, l);
			exp_q.push_back(1'b0);
			host.tick(4);
			foreach (exp_q[i])
			begin
				check("air bit", 32'(o_air_bit), 32'(exp_q[i]));
				host.tick(10);
			end
			check("airtime", air_len, (n + (l ? 16 : 8) + 9) * 10);
			$display("burst transmit test done");
			host.configure(cfg | 24'h000001);
			wr(REG_ADDR_LO, 32'(adr));
			wr(REG_PAYLOAD_W, 32'(plen));
			host.enable(1'b1);
			wait_hi(o_demod_on, 2100, w);
			check("rx start", 32'(w > 2015 && w < 2030), 32'h1);
			frame(v, n, l);
			air_feed();
			wait_hi(o_rx_ready_first, 30, w);
			check("data ready", 32'(o_rx_ready_first), 32'h1);
			host.fetch(plen, got);
			check("payload", got[31:0], v[31:0] & ((32'h1 << plen) - 32'h1));
			wait_hi(o_demod_on, 2100, w);
			exp_q[exp_q.size() - 1] = ~exp_q[exp_q.size() - 1];
			air_feed();
			host.tick(30);
			check("bad crc ready", 32'(o_rx_ready_first), 32'h0);
			rd(REG_STATUS, d);
			check("crc error", 32'(d[ST_CRC_ERR_BIT]), 32'h1);
			wr(REG_STATUS, 32'h100);
			rd(REG_STATUS, d);
			check("crc clear", 32'(d[ST_CRC_ERR_BIT]), 32'h0);
			host.enable(1'b0);
			$display("burst receive test done");
		end
		// direct receive passes every bit straight through
		host.configure(24'h212F05);
		host.enable(1'b1);
		wait_hi(o_demod_on, 2100, w);
		check("direct rx start", 32'(w > 2015 && w < 2030), 32'h1);
		for (k = 0; k < 8; k++)
		begin
			@(posedge i_sys_clk);
			i_air_bit <= 1'($urandom);
			repeat (2) @(posedge i_sys_clk);
			check("direct rx bit", 32'(o_data), 32'(i_air_bit));
			check("direct rx oe", 32'(o_data_oe), 32'h1);
		end
		host.enable(1'b0);
		host.configure(24'h212F04);
		host.enable(1'b1);
		fork
			host.direct(230);
			wait_hi(o_air_active, 2100, w);
		join
		check("direct tx start", 32'(w > 2015 && w < 2030), 32'h1);
		check("direct tx bit", 32'(o_air_bit), 32'h1);
		host.enable(1'b0);
		$display("direct mode test done");
		i_rstn <= 1'b0;
		host.tick(3);
		i_rstn <= 1'b1;
		rd(REG_CONFIG, d);
		check("config after reset", d, {8'h00, CFG_RESET});
		rd(REG_STATUS, d);
		check("configured after reset", 32'(d[4]), 32'h0);
		$display("mid-run reset test done");
		i_pwr_up <= 1'b0;
		host.tick(10);
		rd(REG_STATUS, d);
		check("sleep again", d & 32'hF, 32'h0);
		$display("power down test done");
		final_report();
	end
endmodule
